// ---- core/amc_pkg.sv ----
// package: register map, field layouts, reset values, command types
package amc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_AEN_GEN = 8'h26;
  localparam logic [7:0] ADDR_AEN_OPST = 8'h28;
  localparam logic [7:0] ADDR_AEN_BUF = 8'h2a;
  localparam logic [7:0] ADDR_AEN_WDG = 8'h2c;
  localparam logic [7:0] ADDR_AEN_PIN = 8'h2e;
  localparam logic [7:0] ADDR_TXCLR = 8'h40;
  localparam logic [7:0] ADDR_RXCLR = 8'h42;
  localparam logic [7:0] ADDR_LSCLR = 8'h44;
  localparam logic [7:0] ADDR_HBCLR = 8'h48;
  localparam logic [7:0] ADDR_SPOR = 8'h4a;
  // implemented-bit masks and reset values of the enable registers
  localparam logic [7:0] MASK_AEN_GEN = 8'h7f;
  localparam logic [7:0] RST_AEN_GEN = 8'h34;
  localparam logic [7:0] MASK_AEN_OPST = 8'h3f;
  localparam logic [7:0] RST_AEN_OPST = 8'h3f;
  localparam logic [7:0] MASK_AEN_BUF = 8'h88;
  localparam logic [7:0] RST_AEN_BUF = 8'h00;
  localparam logic [7:0] MASK_AEN_WDG = 8'h1f;
  localparam logic [7:0] RST_AEN_WDG = 8'h00;
  localparam logic [7:0] MASK_AEN_PIN = 8'h0f;
  localparam logic [7:0] RST_AEN_PIN = 8'h00;
  localparam int SPOR_BIT = 0;
  localparam int NUM_AEN = 5;
  localparam logic [7:0] ZERO8 = 8'h00;
  // host register port transaction
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } amc_req_t;
  // one-cycle command pulses towards the datapath
  typedef struct packed {
    logic tx_clr;
    logic rx_clr;
    logic ls_clr;
    logic hb_clr;
  } amc_cmd_t;
  // status and error sources, one vector per enable register
  typedef struct packed {
    logic [7:0] gen;
    logic [7:0] opst;
    logic [7:0] buff;
    logic [7:0] wdg;
    logic [7:0] pin;
  } amc_src_t;
endpackage : amc_pkg

// ---- core/amc_cmd_gate.sv ----
// command gate: decides whether a clear command may execute
`timescale 1ns/10ps
module amc_cmd_gate
  import amc_pkg::*;
(
  input wire logic clr_wr_i,
  input wire logic sleep_busy_i,
  input wire logic verify_busy_i,
  input wire logic load_busy_i,
  input wire logic safemon_i,
  output logic accept_o,
  output logic refuse_o
);
  logic blocked;
  // any background process or safe monitoring blocks clears
  always_comb
  begin
    blocked = sleep_busy_i | verify_busy_i | load_busy_i | safemon_i;
    accept_o = clr_wr_i & ~blocked;
    refuse_o = clr_wr_i & blocked;
  end
endmodule : amc_cmd_gate

// ---- core/amc_alert_mask.sv ----
// alert mask: gates each source by its enable bit onto one alert level
`timescale 1ns/10ps
module amc_alert_mask
  import amc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire amc_src_t src_i,
  input wire amc_src_t en_i,
  output logic alert_o
);
  logic alert_r;
  logic alert_nxt;
  // registered so the pin never glitches on source changes
  always_comb
  begin
    alert_nxt = |(src_i & en_i);
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      alert_r <= 1'b0;
    else
      alert_r <= alert_nxt;
  end
  assign alert_o = alert_r;
endmodule : amc_alert_mask

// ---- core/amc_regs.sv ----
// alert enable masks and self-acting command registers
`timescale 1ns/10ps
module amc_regs
  import amc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire amc_req_t req_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  input wire logic sleep_busy_i,
  input wire logic verify_busy_i,
  input wire logic load_busy_i,
  input wire logic safemon_i,
  input wire logic [DATA_W-1:0] hb_queue_i,
  input wire logic [DATA_W-1:0] hb_seed_wdata_i,
  input wire logic hb_seed_we_i,
  output logic [DATA_W-1:0] hb_seed_o,
  input wire amc_src_t src_i,
  output logic alert_o,
  output amc_cmd_t cmd_o,
  output logic host_port_error_flag_o,
  output logic heartbeat_error_flag_o,
  input wire logic host_err_clr_i,
  input wire logic hb_err_clr_i,
  output logic soft_power_on_reset_o
);
  logic [DATA_W-1:0] aen_r [NUM_AEN];
  logic [DATA_W-1:0] aen_nxt [NUM_AEN];
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  amc_cmd_t cmd_r;
  amc_cmd_t cmd_nxt;
  logic herr_r;
  logic herr_nxt;
  logic hberr_r;
  logic hberr_nxt;
  logic [DATA_W-1:0] seed_r;
  logic [DATA_W-1:0] seed_nxt;
  logic spor_r;
  logic spor_nxt;
  logic clr_wr;
  logic accept;
  logic refuse;
  amc_src_t en_vec;

  // index of an enable register for an address, or NUM_AEN if none
  function automatic int aen_index(input logic [ADDR_W-1:0] a);
    if (a == ADDR_AEN_GEN)
      return 0;
    else if (a == ADDR_AEN_OPST)
      return 1;
    else if (a == ADDR_AEN_BUF)
      return 2;
    else if (a == ADDR_AEN_WDG)
      return 3;
    else if (a == ADDR_AEN_PIN)
      return 4;
    else
      return NUM_AEN;
  endfunction : aen_index

  function automatic logic [DATA_W-1:0] aen_mask(input int i);
    case (i)
      0: return MASK_AEN_GEN;
      1: return MASK_AEN_OPST;
      2: return MASK_AEN_BUF;
      3: return MASK_AEN_WDG;
      default: return MASK_AEN_PIN;
    endcase
  endfunction : aen_mask

  function automatic logic [DATA_W-1:0] aen_reset(input int i);
    case (i)
      0: return RST_AEN_GEN;
      1: return RST_AEN_OPST;
      2: return RST_AEN_BUF;
      3: return RST_AEN_WDG;
      default: return RST_AEN_PIN;
    endcase
  endfunction : aen_reset

  // a write to any of the four clear command addresses
  assign clr_wr = req_i.wr & ((req_i.addr == ADDR_TXCLR) |
                              (req_i.addr == ADDR_RXCLR) |
                              (req_i.addr == ADDR_LSCLR) |
                              (req_i.addr == ADDR_HBCLR));

  amc_cmd_gate u_gate (
    .clr_wr_i(clr_wr),
    .sleep_busy_i(sleep_busy_i),
    .verify_busy_i(verify_busy_i),
    .load_busy_i(load_busy_i),
    .safemon_i(safemon_i),
    .accept_o(accept),
    .refuse_o(refuse)
  );

  // enable register writes; unimplemented bits stay zero
  always_comb
  begin
    int k;
    k = aen_index(req_i.addr);
    for (int i = 0; i < NUM_AEN; i++)
      aen_nxt[i] = aen_r[i];
    if (req_i.wr && k < NUM_AEN)
      aen_nxt[k] = req_i.wdata & aen_mask(k);
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < NUM_AEN; i++)
        aen_r[i] <= aen_reset(i);
    end
    else
    begin
      for (int i = 0; i < NUM_AEN; i++)
        aen_r[i] <= aen_nxt[i];
    end
  end

  // read path: commands are write-only and read back zero
  always_comb
  begin
    int k;
    k = aen_index(req_i.addr);
    rvalid_nxt = req_i.rd;
    rdata_nxt = ZERO8;
    if (req_i.rd && k < NUM_AEN)
      rdata_nxt = aen_r[k];
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_r <= ZERO8;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // command pulses, error flags and the heartbeat seed
  always_comb
  begin
    cmd_nxt = '0;
    herr_nxt = herr_r;
    hberr_nxt = hberr_r;
    seed_nxt = seed_r;
    spor_nxt = 1'b0;
    if (host_err_clr_i)
      herr_nxt = 1'b0;
    if (hb_err_clr_i)
      hberr_nxt = 1'b0;
    if (hb_seed_we_i)
      seed_nxt = hb_seed_wdata_i;
    // set wins over a same-cycle clear
    if (refuse)
      herr_nxt = 1'b1;
    if (accept)
    begin
      cmd_nxt.tx_clr = (req_i.addr == ADDR_TXCLR);
      cmd_nxt.rx_clr = (req_i.addr == ADDR_RXCLR);
      cmd_nxt.ls_clr = (req_i.addr == ADDR_LSCLR);
      if (req_i.addr == ADDR_HBCLR)
      begin
        // a live queue would be corrupted by reseeding
        if (hb_queue_i != ZERO8)
          hberr_nxt = 1'b1;
        else
        begin
          seed_nxt = ZERO8;
          cmd_nxt.hb_clr = 1'b1;
        end
      end
    end
    // only a 1 in bit 0 fires; a 0 leaves everything alone
    if (req_i.wr && req_i.addr == ADDR_SPOR && req_i.wdata[SPOR_BIT])
      spor_nxt = 1'b1;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cmd_r <= '0;
      herr_r <= 1'b0;
      hberr_r <= 1'b0;
      seed_r <= ZERO8;
      spor_r <= 1'b0;
    end
    else
    begin
      cmd_r <= cmd_nxt;
      herr_r <= herr_nxt;
      hberr_r <= hberr_nxt;
      seed_r <= seed_nxt;
      spor_r <= spor_nxt;
    end
  end

  assign en_vec = '{gen: aen_r[0], opst: aen_r[1], buff: aen_r[2],
                    wdg: aen_r[3], pin: aen_r[4]};

  amc_alert_mask u_alert (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .src_i(src_i),
    .en_i(en_vec),
    .alert_o(alert_o)
  );

  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign cmd_o = cmd_r;
  assign host_port_error_flag_o = herr_r;
  assign heartbeat_error_flag_o = hberr_r;
  assign hb_seed_o = seed_r;
  // the pulse is fed to the chip reset tree outside this block
  assign soft_power_on_reset_o = spor_r;

  sequence s_refused;
    refuse;
  endsequence
  sequence s_flag_up;
    ##1 host_port_error_flag_o;
  endsequence
  property p_refuse_flag;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      s_refused |-> s_flag_up;
  endproperty
  a_refuse_flag: assert property (p_refuse_flag)
    else $error("refused command did not raise host port error");

  property p_block_busy;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (clr_wr && (sleep_busy_i || verify_busy_i || load_busy_i))
      |=> cmd_o == '0;
  endproperty
  a_block_busy: assert property (p_block_busy)
    else $error("clear executed during a busy process");

  // a datapath seed load in the same cycle may legally move the seed
  property p_block_safemon;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (clr_wr && safemon_i && !hb_seed_we_i)
      |=> (cmd_o == '0) && $stable(hb_seed_o);
  endproperty
  a_block_safemon: assert property (p_block_safemon)
    else $error("clear executed in safe monitoring");

  // back-to-back accepted clears may keep the pulse high one more cycle
  property p_tx_clr;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (accept && req_i.addr == ADDR_TXCLR) |=> cmd_o.tx_clr ##1
      (!cmd_o.tx_clr || $past(accept && req_i.addr == ADDR_TXCLR));
  endproperty
  a_tx_clr: assert property (p_tx_clr)
    else $error("transmit clear pulse wrong");

  property p_rx_clr;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      cmd_o.rx_clr |-> $past(accept) && $past(req_i.addr) == ADDR_RXCLR;
  endproperty
  a_rx_clr: assert property (p_rx_clr)
    else $error("receive clear without accepted command");

  property p_ls_clr;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (accept && req_i.addr == ADDR_LSCLR) |=> cmd_o.ls_clr;
  endproperty
  a_ls_clr: assert property (p_ls_clr)
    else $error("lockstep clear not issued");

  property p_hb_busy;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (accept && req_i.addr == ADDR_HBCLR && hb_queue_i != ZERO8
       && !hb_seed_we_i) |=> heartbeat_error_flag_o && $stable(hb_seed_o);
  endproperty
  a_hb_busy: assert property (p_hb_busy)
    else $error("seed clear with live queue not refused");

  property p_spor;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      soft_power_on_reset_o |-> $past(req_i.wr) &&
      $past(req_i.addr) == ADDR_SPOR && $past(req_i.wdata[SPOR_BIT]);
  endproperty
  a_spor: assert property (p_spor)
    else $error("soft reset pulse without a write of one");
endmodule : amc_regs

// ---- tb/amc_host_model.sv ----
// host model: drives register port requests and collects read answers
`timescale 1ns/10ps
module amc_host_model
  import amc_pkg::*;
(
  input wire logic clk_sys_i,
  output amc_req_t req_o,
  input wire logic [DATA_W-1:0] rdata_i,
  input wire logic rvalid_i
);
  initial req_o = '0;

  // one-cycle write; released fields show inverted data, not stale values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    req_o = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys_i);
    req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr

  // one-cycle read, answer awaited for a bounded number of cycles
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 'x;
    @(negedge clk_sys_i);
    req_o = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys_i);
    req_o = '{1'b0, 1'b0, ~a, 8'hff};
    for (int i = 0; i < 4 && !ok; i++)
    begin
      if (rvalid_i === 1'b1)
      begin
        d = rdata_i;
        ok = 1'b1;
      end
      else
        @(negedge clk_sys_i);
    end
  endtask : rd
endmodule : amc_host_model

// ---- tb/alert_mask_and_command_regs_test.sv ----
// testbench: register bank, command gating and alert masking checks
`timescale 1ns/10ps
module alert_mask_and_command_regs_test;
  import amc_pkg::*;
  logic clk_sys_i, nrst_i, hclr, hbclr, seed_we;
  logic [3:0] busy;
  logic [7:0] hb_q, hb_wd, rdata, seed, d;
  logic rvalid, alert, hperr, hberr, spor;
  logic [7:0] en [5];
  amc_req_t req;
  amc_src_t src;
  amc_cmd_t cmd, seen;
  int error_cnt, checks_done, nspor;
  bit ok;
  localparam logic [7:0] AA [5] = '{ADDR_AEN_GEN, ADDR_AEN_OPST,
    ADDR_AEN_BUF, ADDR_AEN_WDG, ADDR_AEN_PIN};
  localparam logic [7:0] RV [5] = '{RST_AEN_GEN, RST_AEN_OPST,
    RST_AEN_BUF, RST_AEN_WDG, RST_AEN_PIN};
  localparam logic [7:0] MK [5] = '{MASK_AEN_GEN, MASK_AEN_OPST,
    MASK_AEN_BUF, MASK_AEN_WDG, MASK_AEN_PIN};
  localparam logic [7:0] CA [4] = '{ADDR_TXCLR, ADDR_RXCLR,
    ADDR_LSCLR, ADDR_HBCLR};

  amc_regs amc_regs_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .sleep_busy_i(busy[3]), .verify_busy_i(busy[2]),
    .load_busy_i(busy[1]), .safemon_i(busy[0]), .hb_queue_i(hb_q),
    .hb_seed_wdata_i(hb_wd), .hb_seed_we_i(seed_we), .hb_seed_o(seed),
    .src_i(src), .alert_o(alert), .cmd_o(cmd),
    .host_port_error_flag_o(hperr), .heartbeat_error_flag_o(hberr),
    .host_err_clr_i(hclr), .hb_err_clr_i(hbclr),
    .soft_power_on_reset_o(spor));
  amc_host_model amc_host_model_inst (.clk_sys_i(clk_sys_i),
    .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  // 100 ns system clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  function automatic amc_cmd_t exp_cmd(input int k);
    return amc_cmd_t'(4'b1000 >> k);
  endfunction : exp_cmd

  // enables are stored already masked, so the or-reduce is the alert level
  function automatic logic exp_alert(input amc_src_t s);
    return |(s & {en[0], en[1], en[2], en[3], en[4]});
  endfunction : exp_alert

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // a read that never answers ends the run as a mismatch
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    amc_host_model_inst.rd(a, d, ok);
    if (!ok)
    begin
      error_cnt++;
      give_verdict();
    end
    chk("rdata", e, d);
  endtask : rchk

  // samples first so a pulse launched by the write edge is not missed
  task automatic watch;
    seen = '0;
    nspor = 0;
    repeat (4)
    begin
      seen = seen | cmd;
      nspor += int'(spor);
      @(negedge clk_sys_i);
    end
  endtask : watch

  task automatic load_seed(input logic [7:0] v);
    @(negedge clk_sys_i);
    hb_wd = v;
    seed_we = 1'b1;
    @(negedge clk_sys_i);
    seed_we = 1'b0;
  endtask : load_seed

  task automatic clr_flags;
    @(negedge clk_sys_i);
    hclr = 1'b1;
    hbclr = 1'b1;
    @(negedge clk_sys_i);
    hclr = 1'b0;
    hbclr = 1'b0;
  endtask : clr_flags

  // main sequence
  initial
  begin
    {hclr, hbclr, seed_we, busy, hb_q, hb_wd} = '0;
    src = '0;
    nrst_i = 1'b0;
    void'($urandom(32'h17c9));
    repeat (10) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    for (int r = 0; r < 5; r++)
      rchk(AA[r], RV[r]);
    amc_host_model_inst.wr(8'h30, 8'hff);
    rchk(8'h30, 8'h00);
    rchk(ADDR_TXCLR, 8'h00);
    load_seed(8'($urandom_range(255, 1)));
    for (int k = 0; k < 4; k++)
    begin
      amc_host_model_inst.wr(CA[k], 8'($urandom));
      watch();
      chk("cmd", 8'(exp_cmd(k)), 8'(seen));
    end
    chk("seed", 8'h00, seed);
    chk("hperr", 8'h00, 8'(hperr));
    for (int j = 0; j < 4; j++)
      for (int k = 0; k < 4; k++)
      begin
        d = 8'($urandom_range(255, 1));
        load_seed(d);
        busy = 4'b1000 >> j;
        amc_host_model_inst.wr(CA[k], 8'($urandom));
        watch();
        chk("cmd", 8'h00, 8'(seen));
        chk("seed", d, seed);
        chk("hperr", 8'h01, 8'(hperr));
        busy = '0;
        clr_flags();
        chk("hperr", 8'h00, 8'(hperr));
      end
    d = 8'($urandom_range(255, 1));
    load_seed(d);
    hb_q = 8'($urandom_range(255, 1));
    amc_host_model_inst.wr(ADDR_HBCLR, 8'h00);
    watch();
    chk("cmd", 8'h00, 8'(seen));
    chk("seed", d, seed);
    chk("hberr", 8'h01, 8'(hberr));
    clr_flags();
    chk("hberr", 8'h00, 8'(hberr));
    amc_host_model_inst.wr(ADDR_SPOR, 8'($urandom) & 8'hfe);
    watch();
    chk("spor", 8'h00, 8'(nspor));
    amc_host_model_inst.wr(ADDR_SPOR, 8'h01);
    watch();
    chk("spor", 8'h01, 8'(nspor));
    rchk(ADDR_SPOR, 8'h00);
    // first pass: all sources high, all enables clear
    for (int i = 0; i < 12; i++)
    begin
      for (int r = 0; r < 5; r++)
      begin
        d = (i == 0) ? 8'h00 : 8'($urandom);
        amc_host_model_inst.wr(AA[r], d);
        en[r] = d & MK[r];
        rchk(AA[r], en[r]);
      end
      src = (i == 0) ? '1 : {$urandom, 8'($urandom)};
      repeat (3) @(negedge clk_sys_i);
      chk("alert", 8'(exp_alert(src)), 8'(alert));
    end
    give_verdict();
  end
endmodule : alert_mask_and_command_regs_test
